// *** hdl/bscb_consts.vh ***
// constants for the boot serial check-data and baud-rate command block
`ifndef BSCB_CONSTS_VH
`define BSCB_CONSTS_VH

// command codes
`define BSCB_CMD_RDCHK 8'hfd
`define BSCB_CMD_B9600 8'hb0
`define BSCB_CMD_B19200 8'hb1
`define BSCB_CMD_B38400 8'hb2
`define BSCB_CMD_B57600 8'hb3

// baud select codes (low two bits of the baud commands)
`define BSCB_SEL_9600 2'h0
`define BSCB_SEL_19200 2'h1
`define BSCB_SEL_38400 2'h2
`define BSCB_SEL_57600 2'h3
`define BSCB_SEL_RESET 2'h0

// clock and rates
`define BSCB_CLK_HZ 20000000
`define BSCB_RATE_9600 9600
`define BSCB_RATE_19200 19200
`define BSCB_RATE_38400 38400
`define BSCB_RATE_57600 57600
`define BSCB_DIV_W 12
// cycles per bit, rounded to nearest
`define BSCB_DIV(r) ((`BSCB_CLK_HZ + ((r) / 2)) / (r))

// check value crc
`define BSCB_CRC_POLY 16'h1021
`define BSCB_CRC_INIT 16'h0000

// frame layout: start, 8 data, stop
`define BSCB_DATA_BITS 4'h8
`define BSCB_TX_BITS 4'ha

// receive fifo
`define BSCB_FIFO_W 8
`define BSCB_FIFO_D 8
`define BSCB_FIFO_AW 3

`endif

// *** hdl/bscb_fifo.v ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bscb_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_sys, // system clock
	input wire resetn, // async reset, active low
	input wire in_valid, // write side valid
	output wire in_ready, // write side ready (not full)
	input wire [WIDTH-1:0] in_data, // write data
	output wire out_valid, // read side valid (not empty)
	input wire out_ready, // read side ready
	output wire [WIDTH-1:0] out_data // read data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire do_wr;
	wire do_rd;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always @(posedge clk_sys) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_wr && !do_rd) begin
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			end else if (do_rd && !do_wr) begin
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // bscb_fifo
`default_nettype wire

// *** hdl/bscb_uart.v ***
// asynchronous serial receiver and transmitter with run-time bit divisor
`timescale 1ns/1ps
`default_nettype none
`include "bscb_consts.vh"
module bscb_uart (
	input wire clk_sys, // system clock
	input wire resetn, // async reset, active low
	input wire [`BSCB_DIV_W-1:0] bit_div, // cycles per bit
	input wire rx_line, // serial input, idle high
	output reg tx_line, // serial output, idle high
	output reg rx_valid, // one-cycle pulse, byte received
	output reg [7:0] rx_data, // received byte
	output reg rx_frame_err, // one-cycle pulse, stop bit low
	input wire tx_start, // start sending tx_data when idle
	input wire [7:0] tx_data, // byte to send
	output reg tx_busy // high from start until stop bit ends
);
	reg rx_in_reg;
	reg rx_busy_reg;
	reg [`BSCB_DIV_W-1:0] rx_cnt_reg;
	reg [3:0] rx_bit_reg;
	reg [8:0] rx_shift_reg;
	reg [`BSCB_DIV_W-1:0] tx_cnt_reg;
	reg [3:0] tx_bit_reg;
	reg [9:0] tx_shift_reg;

	// framing comes from the data line alone: start edge, then mid-bit sampling
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_in_reg <= 1'b1;
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= {`BSCB_DIV_W{1'b0}};
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 9'h000;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_frame_err <= 1'b0;
		end else begin
			rx_in_reg <= rx_line;
			rx_valid <= 1'b0;
			rx_frame_err <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rx_in_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg <= {1'b0, bit_div[`BSCB_DIV_W-1:1]};
					rx_bit_reg <= 4'h0;
				end
			end else if (rx_cnt_reg != {`BSCB_DIV_W{1'b0}}) begin
				rx_cnt_reg <= rx_cnt_reg - {{(`BSCB_DIV_W-1){1'b0}}, 1'b1};
			end else begin
				rx_cnt_reg <= bit_div - {{(`BSCB_DIV_W-1){1'b0}}, 1'b1};
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0) begin
					// glitch on the line, not a real start bit
					if (rx_in_reg) begin
						rx_busy_reg <= 1'b0;
					end
				end else if (rx_bit_reg <= `BSCB_DATA_BITS) begin
					rx_shift_reg <= {rx_in_reg, rx_shift_reg[8:1]};
				end else begin
					rx_busy_reg <= 1'b0;
					if (rx_in_reg) begin
						rx_valid <= 1'b1;
						rx_data <= rx_shift_reg[8:1];
					end else begin
						rx_frame_err <= 1'b1;
					end
				end
			end
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_line <= 1'b1;
			tx_busy <= 1'b0;
			tx_cnt_reg <= {`BSCB_DIV_W{1'b0}};
			tx_bit_reg <= 4'h0;
			tx_shift_reg <= 10'h3ff;
		end else begin
			if (!tx_busy) begin
				tx_line <= 1'b1;
				if (tx_start) begin
					tx_busy <= 1'b1;
					tx_shift_reg <= {1'b1, tx_data, 1'b0};
					tx_cnt_reg <= {`BSCB_DIV_W{1'b0}};
					tx_bit_reg <= 4'h0;
				end
			end else if (tx_cnt_reg != {`BSCB_DIV_W{1'b0}}) begin
				tx_cnt_reg <= tx_cnt_reg - {{(`BSCB_DIV_W-1){1'b0}}, 1'b1};
			end else if (tx_bit_reg == `BSCB_TX_BITS) begin
				// busy covers the whole stop bit, so a rate change waits for it
				tx_busy <= 1'b0;
			end else begin
				tx_line <= tx_shift_reg[0];
				tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
				tx_bit_reg <= tx_bit_reg + 4'h1;
				tx_cnt_reg <= bit_div - {{(`BSCB_DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // bscb_uart
`default_nettype wire

// *** hdl/bscb_top.v ***
// boot serial command handler: read-check-data and baud-rate commands
// Functional notes
// - command byte fd requests the check value
// - reply check value low byte, then high
// - clear accumulator as the report starts, then accumulate again
// - check value is crc of program data
// - b0 echoes b0, then runs 9600 bps
// - b1 echoes b1, then runs 19200 bps
// - b2 echoes b2, then runs 38400 bps
// - b3 echoes b3, then runs 57600 bps
// - echo finishes at old rate before switching
// - link is asynchronous, no shift clock
// - refuse commands while id check fails
`timescale 1ns/1ps
`default_nettype none
`include "bscb_consts.vh"
module bscb_top (
	input wire clk_sys, // system clock, 20 MHz
	input wire resetn, // async reset, active low
	input wire host_to_device_serial_in, // serial data from host
	output reg device_to_host_serial_out, // serial data to host
	input wire pgm_data_valid, // one-cycle pulse per page program data byte
	input wire [7:0] pgm_data, // page program data byte
	input wire id_locked, // flash not blank and id not matched
	output reg [1:0] baud_sel_reg, // current link rate select
	output reg busy_reg, // command in progress
	output reg cmd_refused_reg, // pulse, command dropped by id lock
	output reg rx_overrun_reg // pulse, received byte lost, fifo full
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_TX_LO = 5'h02;
	localparam [4:0] ST_TX_HI = 5'h04;
	localparam [4:0] ST_ECHO = 5'h08;
	localparam [4:0] ST_DONE = 5'h10;

	// divisors are worked out wide, then cut to the counter width on purpose
	localparam [31:0] DIV_9600_W = `BSCB_DIV(`BSCB_RATE_9600);
	localparam [31:0] DIV_19200_W = `BSCB_DIV(`BSCB_RATE_19200);
	localparam [31:0] DIV_38400_W = `BSCB_DIV(`BSCB_RATE_38400);
	localparam [31:0] DIV_57600_W = `BSCB_DIV(`BSCB_RATE_57600);
	localparam [`BSCB_DIV_W-1:0] DIV_9600 = DIV_9600_W[`BSCB_DIV_W-1:0];
	localparam [`BSCB_DIV_W-1:0] DIV_19200 = DIV_19200_W[`BSCB_DIV_W-1:0];
	localparam [`BSCB_DIV_W-1:0] DIV_38400 = DIV_38400_W[`BSCB_DIV_W-1:0];
	localparam [`BSCB_DIV_W-1:0] DIV_57600 = DIV_57600_W[`BSCB_DIV_W-1:0];

	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg [15:0] crc_reg;
	reg [7:0] chk_hi_reg;
	reg [1:0] baud_pend_reg;
	reg [`BSCB_DIV_W-1:0] bit_div_reg;
	reg tx_start;
	reg [7:0] tx_byte;
	reg fifo_pop;
	wire tx_line;
	wire tx_busy;
	wire rx_valid;
	wire [7:0] rx_data;
	wire rx_ready;
	wire cmd_valid;
	wire [7:0] cmd_byte;
	wire is_rdchk;
	wire is_baud;

	function baud_cmd;
		input [7:0] b;
		begin
			baud_cmd = (b == `BSCB_CMD_B9600) || (b == `BSCB_CMD_B19200) ||
				(b == `BSCB_CMD_B38400) || (b == `BSCB_CMD_B57600);
		end
	endfunction

	function [`BSCB_DIV_W-1:0] sel_div;
		input [1:0] sel;
		begin
			case (sel)
				`BSCB_SEL_9600: sel_div = DIV_9600;
				`BSCB_SEL_19200: sel_div = DIV_19200;
				`BSCB_SEL_38400: sel_div = DIV_38400;
				default: sel_div = DIV_57600;
			endcase
		end
	endfunction

	// msb-first crc-16 step over one byte
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c;
			for (i = 7; i >= 0; i = i - 1) begin
				if (r[15] ^ d[i]) begin
					r = {r[14:0], 1'b0} ^ `BSCB_CRC_POLY;
				end else begin
					r = {r[14:0], 1'b0};
				end
			end
			crc_byte = r;
		end
	endfunction

	bscb_uart u_uart (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.bit_div(bit_div_reg),
		.rx_line(host_to_device_serial_in),
		.tx_line(tx_line),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_frame_err(),
		.tx_start(tx_start),
		.tx_data(tx_byte),
		.tx_busy(tx_busy)
	);

	// received bytes queue here while a reply is still going out
	bscb_fifo #(
		.WIDTH(`BSCB_FIFO_W),
		.DEPTH(`BSCB_FIFO_D),
		.AW(`BSCB_FIFO_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(cmd_valid),
		.out_ready(fifo_pop),
		.out_data(cmd_byte)
	);

	assign is_rdchk = (cmd_byte == `BSCB_CMD_RDCHK);
	assign is_baud = baud_cmd(cmd_byte);

	always @* begin
		state_next = state_reg;
		tx_start = 1'b0;
		tx_byte = cmd_byte;
		fifo_pop = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// commands are taken one at a time, only with the transmitter idle
				if (cmd_valid && !tx_busy) begin
					fifo_pop = 1'b1;
					if (id_locked) begin
						state_next = ST_IDLE;
					end else if (is_rdchk) begin
						tx_start = 1'b1;
						tx_byte = crc_reg[7:0];
						state_next = ST_TX_LO;
					end else if (is_baud) begin
						tx_start = 1'b1;
						tx_byte = cmd_byte;
						state_next = ST_ECHO;
					end
				end
			end
			ST_TX_LO: begin
				if (!tx_busy) begin
					tx_start = 1'b1;
					tx_byte = chk_hi_reg;
					state_next = ST_TX_HI;
				end
			end
			ST_TX_HI: begin
				if (!tx_busy) begin
					state_next = ST_IDLE;
				end
			end
			ST_ECHO: begin
				if (!tx_busy) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			crc_reg <= `BSCB_CRC_INIT;
			chk_hi_reg <= 8'h00;
			baud_pend_reg <= `BSCB_SEL_RESET;
			baud_sel_reg <= `BSCB_SEL_RESET;
			bit_div_reg <= DIV_9600;
			device_to_host_serial_out <= 1'b1;
			busy_reg <= 1'b0;
			cmd_refused_reg <= 1'b0;
			rx_overrun_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			device_to_host_serial_out <= tx_line;
			busy_reg <= (state_next != ST_IDLE);
			cmd_refused_reg <= fifo_pop && id_locked;
			rx_overrun_reg <= rx_valid && !rx_ready;
			// report snapshots the value; data in the same cycle starts the new run
			if (state_reg == ST_IDLE && fifo_pop && !id_locked && is_rdchk) begin
				chk_hi_reg <= crc_reg[15:8];
				if (pgm_data_valid) begin
					crc_reg <= crc_byte(`BSCB_CRC_INIT, pgm_data);
				end else begin
					crc_reg <= `BSCB_CRC_INIT;
				end
			end else if (pgm_data_valid) begin
				crc_reg <= crc_byte(crc_reg, pgm_data);
			end
			if (state_reg == ST_IDLE && fifo_pop && !id_locked && is_baud) begin
				baud_pend_reg <= cmd_byte[1:0];
			end
			// divisor changes only once the echo stop bit is out
			if (state_reg == ST_DONE) begin
				baud_sel_reg <= baud_pend_reg;
				bit_div_reg <= sel_div(baud_pend_reg);
			end
		end
	end
endmodule // bscb_top
`default_nettype wire

// *** tb/bscb_properties.sv ***
// port assertions for the boot serial command block
`timescale 1ns/1ps
`default_nettype none
module bscb_properties (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic host_to_device_serial_in, // from host
	input wire logic device_to_host_serial_out, // to host
	input wire logic pgm_data_valid, // program byte strobe
	input wire logic [7:0] pgm_data, // program byte
	input wire logic id_locked, // commands refused
	input wire logic [1:0] baud_sel_reg, // link rate
	input wire logic busy_reg, // command running
	input wire logic cmd_refused_reg, // refusal pulse
	input wire logic rx_overrun_reg // overrun pulse
);
	logic [15:0] low_cnt;
	logic [15:0] cur_div;
	// a run of zero bits spans several bit times, so only a lower bound holds
	assign cur_div = baud_sel_reg == 2'h0 ? 16'h0823 : baud_sel_reg == 2'h1 ? 16'h0412 :
		baud_sel_reg == 2'h2 ? 16'h0209 : 16'h015b;
	always @(posedge clk_sys or negedge resetn)
		if (!resetn)
			low_cnt <= 16'h0000;
		else
			low_cnt <= device_to_host_serial_out ? 16'h0000 : low_cnt + 16'h0001;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	bit_width_a:
		assert property ($rose(device_to_host_serial_out) |-> low_cnt >= cur_div)
		else $error("low run on serial out shorter than one bit");
	idle_high_a:
		assert property (!busy_reg [*3] |-> device_to_host_serial_out)
		else $error("serial out low while idle");
	rate_hold_a:
		assert property ($changed(baud_sel_reg) |-> $past(busy_reg))
		else $error("rate changed outside a command");
	rate_frame_a:
		assert property (!device_to_host_serial_out |=> $stable(baud_sel_reg))
		else $error("rate changed during a frame");
	end_stop_a:
		assert property ($fell(busy_reg) |-> device_to_host_serial_out)
		else $error("command ended before the stop bit");
	refuse_lock_a:
		assert property (cmd_refused_reg |-> id_locked || $past(id_locked))
		else $error("refusal without lock");
	refuse_pulse_a:
		assert property (cmd_refused_reg |=> !cmd_refused_reg)
		else $error("refusal pulse too long");
	lock_quiet_a:
		assert property (id_locked [*8] ##0 !busy_reg |=> !busy_reg)
		else $error("command started while locked");
endmodule // bscb_properties
`default_nettype wire

// *** tb/bscb_host_model.sv ***
// host side serial model: 8N1 frames at a selectable rate
`timescale 1ns/1ps
`default_nettype none
module bscb_host_model (
	input wire logic clk_sys, // system clock
	output logic tx, // line to device, idle high
	input wire logic rx // line from device
);
	logic [1:0] sel = 2'h0; // changed by the bench only after an echo
	function automatic int bit_cyc(input logic [1:0] s);
		return s == 2'h0 ? 2083 : s == 2'h1 ? 1042 : s == 2'h2 ? 521 : 347;
	endfunction
	initial tx = 1'b1;
	// framing from the data line alone, no shift clock
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx <= f[i];
			repeat (bit_cyc(sel)) @(posedge clk_sys);
		end
	endtask
	task automatic recv(output logic [7:0] b, output logic ok);
		@(negedge rx);
		repeat (bit_cyc(sel) / 2) @(posedge clk_sys);
		ok = !rx;
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc(sel)) @(posedge clk_sys);
			b[i] = rx;
		end
		repeat (bit_cyc(sel)) @(posedge clk_sys);
		ok = ok & rx;
	endtask
endmodule // bscb_host_model
`default_nettype wire

// *** tb/tb.sv ***
// testbench for the boot serial command block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys, resetn, h2d, d2h, pgm_data_valid, id_locked, busy, refused, overrun;
	logic [7:0] pgm_data;
	logic [1:0] baud_sel_reg;
	logic [15:0] refused_cnt = 16'h0000;
	logic [15:0] overrun_cnt = 16'h0000;
	int failures = 0;
	int checks = 0;
	bscb_top DUT (.clk_sys(clk_sys), .resetn(resetn), .host_to_device_serial_in(h2d),
		.device_to_host_serial_out(d2h), .pgm_data_valid(pgm_data_valid), .pgm_data(pgm_data),
		.id_locked(id_locked), .baud_sel_reg(baud_sel_reg), .busy_reg(busy),
		.cmd_refused_reg(refused), .rx_overrun_reg(overrun));
	bscb_host_model host (.clk_sys(clk_sys), .tx(h2d), .rx(d2h));
	always @(posedge clk_sys)
		refused_cnt <= refused_cnt + {15'h0000, refused};
	always @(posedge clk_sys)
		overrun_cnt <= overrun_cnt + {15'h0000, overrun};
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int k = 0; k < 8; k++)
			c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
		return c;
	endfunction
	// reply bytes are collected while the command is still going out
	task automatic xfer(input logic [7:0] c, input int n, output logic [15:0] r);
		logic [7:0] b;
		logic ok;
		r = 16'h0000;
		fork
			host.send(c);
			for (int i = 0; i < n; i++) begin
				host.recv(b, ok);
				check("reply framing", 16'h0001, {15'h0000, ok});
				r = {b, r[15:8]};
			end
		join
	endtask
	task automatic t_baud(input logic [7:0] c);
		logic [15:0] r;
		xfer(c, 1, r);
		check("echo", {c, 8'h00}, r);
		repeat (host.bit_cyc(host.sel) + 10) @(posedge clk_sys);
		check("rate", {14'h0000, c[1:0]}, {14'h0000, baud_sel_reg});
		host.sel = c[1:0];
		$display("test baud %h done", c);
	endtask
	task automatic t_lock;
		logic [15:0] r, n0;
		id_locked <= 1'b1;
		n0 = refused_cnt;
		xfer(8'hb0, 0, r);
		repeat (300) @(posedge clk_sys);
		check("refusals", n0 + 16'h0001, refused_cnt);
		check("rate kept", 16'h0003, {14'h0000, baud_sel_reg});
		check("no reply", 16'h0001, {15'h0000, d2h});
		id_locked <= 1'b0;
		$display("test lock done");
	endtask
	task automatic t_check;
		logic [15:0] r, crc;
		logic [7:0] d [4];
		d = '{8'h00, 8'hff, 8'h5a, 8'h31};
		crc = 16'h0000;
		// back to back program bytes, then the host reads the check value twice, the second after the clear
		for (int i = 0; i < 4; i++) begin
			pgm_data_valid <= 1'b1;
			pgm_data <= d[i];
			crc = crc_byte(crc, d[i]);
			@(posedge clk_sys);
		end
		pgm_data_valid <= 1'b0;
		xfer(8'hfd, 2, r);
		check("check value", crc, r);
		xfer(8'hfd, 2, r);
		check("cleared value", 16'h0000, r);
		check("no overrun", 16'h0000, overrun_cnt);
		$display("test check data done");
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		resetn = 1'b0;
		pgm_data_valid = 1'b0;
		pgm_data = 8'h00;
		id_locked = 1'b0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		check("reset rate", 16'h0000, {14'h0000, baud_sel_reg});
		check("reset line", 16'h0001, {15'h0000, d2h});
		t_baud(8'hb3);
		t_lock;
		t_check;
		t_baud(8'hb2);
		t_baud(8'hb1);
		t_baud(8'hb0);
		print_verdict;
	end
	initial begin
		repeat (120000) @(posedge clk_sys);
		failures++;
		print_verdict;
	end
endmodule // tb
bind bscb_top bscb_properties u_props (.clk_sys(clk_sys), .resetn(resetn),
	.host_to_device_serial_in(host_to_device_serial_in),
	.device_to_host_serial_out(device_to_host_serial_out), .pgm_data_valid(pgm_data_valid),
	.pgm_data(pgm_data), .id_locked(id_locked), .baud_sel_reg(baud_sel_reg),
	.busy_reg(busy_reg), .cmd_refused_reg(cmd_refused_reg), .rx_overrun_reg(rx_overrun_reg));
`default_nettype wire
